// *** verilog/scq_master.sv ***
// Single-master two-wire bus controller with command and response queues.
// Assumes external pull-ups on both lines and a host on the same clock.
`timescale 1ns/100ps
`default_nettype none
module scq_master
    import scq_pkg::*;
#(
    parameter int PERIOD_CYCLES = SCQ_PERIOD_CYCLES,
    parameter int SDA_DELAY_CYCLES = SCQ_SDA_DELAY_CYCLES,
    parameter int CMD_DEPTH = SCQ_CMD_DEPTH,
    parameter int CMD_DEPTH_LOG2 = SCQ_CMD_DEPTH_LOG2,
    parameter int RSP_DEPTH = SCQ_RSP_DEPTH,
    parameter int RSP_DEPTH_LOG2 = SCQ_RSP_DEPTH_LOG2
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic [3:0] cmd_code_in,
    input wire logic [7:0] cmd_data_in,
    input wire logic cmd_valid_in,
    output logic cmd_ready_out,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_out,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    output logic [3:0] rsp_code_out,
    output logic [7:0] rsp_data_out,
    output logic rsp_valid_out,
    input wire logic rsp_ready_in,
    output logic busy_out
);
    localparam int HALF = PERIOD_CYCLES / 2;
    localparam int CW = $clog2(PERIOD_CYCLES + SDA_DELAY_CYCLES + 1);
    localparam logic [CW-1:0] PERIOD_LAST = CW'(PERIOD_CYCLES - 1);
    localparam logic [CW-1:0] HALF_AT = CW'(HALF);
    localparam logic [CW-1:0] DELAY_AT = CW'(SDA_DELAY_CYCLES);
    // Data is loaded one count early so it lands exactly the delay after the clock falls between bits of one command; a command's first bit lands later
    localparam logic [CW-1:0] SDA_AT = CW'(SDA_DELAY_CYCLES - 1);
    localparam logic [CW-1:0] SAMPLE_AT = CW'(HALF + (PERIOD_CYCLES - HALF) / 2);
    initial begin
        if (PERIOD_CYCLES < SCQ_MIN_PERIOD) begin
            $error("Clock period must be at least four cycles");
        end
        if (SDA_DELAY_CYCLES < SCQ_MIN_SDA_DELAY || SDA_DELAY_CYCLES >= HALF) begin
            $error("Data delay must be at least two and below half a period");
        end
        if (CMD_DEPTH < SCQ_MIN_DEPTH || RSP_DEPTH < SCQ_MIN_DEPTH) begin
            $error("Queue depths must be at least two");
        end
    end

    typedef struct packed {
        scq_state_t state;
        logic [CW-1:0] cnt;
        logic [3:0] bits;
        logic [3:0] code;
        logic [7:0] shift;
        logic owned;
        logic scl;
        logic sda;
        logic [3:0] rsp_code;
        logic [7:0] rsp_data;
        logic rsp_push;
    } scq_ctl_t;
    scq_ctl_t s_q;
    scq_ctl_t s_d;

    logic cmd_q_ready;
    logic cmd_q_valid;
    logic [SCQ_ENTRY_W-1:0] cmd_q_data;
    logic cmd_pop;
    logic rsp_q_ready;
    logic sda_sync;
    logic scl_sync;
    logic reset_cmd;

    // Command ready waits for room in both queues
    assign cmd_ready_out = cmd_q_ready && rsp_q_ready;
    assign cmd_pop = (s_q.state == SCQ_FETCH) && cmd_q_valid;
    assign reset_cmd = cmd_pop && (cmd_q_data[11:8] == SCQ_CMD_RESET);

    scq_fifo #(.WIDTH(SCQ_ENTRY_W), .DEPTH(CMD_DEPTH), .DEPTH_LOG2(CMD_DEPTH_LOG2)) u_cmd_fifo (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .enable_in(enable_in),
        .clear_in(1'b0),
        .in_valid_in(cmd_valid_in && rsp_q_ready),
        .in_ready_out(cmd_q_ready),
        .in_data_in({cmd_code_in, cmd_data_in}),
        .out_valid_out(cmd_q_valid),
        .out_ready_in(cmd_pop),
        .out_data_out(cmd_q_data)
    );

    scq_fifo #(.WIDTH(SCQ_ENTRY_W), .DEPTH(RSP_DEPTH), .DEPTH_LOG2(RSP_DEPTH_LOG2)) u_rsp_fifo (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .enable_in(enable_in),
        .clear_in(reset_cmd),
        .in_valid_in(s_q.rsp_push),
        .in_ready_out(rsp_q_ready),
        .in_data_in({s_q.rsp_code, s_q.rsp_data}),
        .out_valid_out(rsp_valid_out),
        .out_ready_in(rsp_ready_in),
        .out_data_out({rsp_code_out, rsp_data_out})
    );

    scq_sync u_sda_sync (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .enable_in(enable_in),
        .async_in(sda_in),
        .sync_out(sda_sync)
    );

    scq_sync u_scl_sync (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .enable_in(enable_in),
        .async_in(scl_in),
        .sync_out(scl_sync)
    );

    function automatic logic is_bit_cmd(input logic [3:0] c);
        is_bit_cmd = (c == SCQ_CMD_ADDR) || (c == SCQ_CMD_WDATA) || (c == SCQ_CMD_RDATA)
            || (c == SCQ_CMD_MASTER_ACK) || (c == SCQ_CMD_MASTER_NOTACK)
            || (c == SCQ_CMD_SLAVE_ACK_CYCLE);
    endfunction

    function automatic logic is_read_cmd(input logic [3:0] c);
        is_read_cmd = (c == SCQ_CMD_RDATA) || (c == SCQ_CMD_SLAVE_ACK_CYCLE);
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.rsp_push = 1'b0;
        case (s_q.state)
            SCQ_IDLE: begin
                s_d.state = SCQ_FETCH;
            end
            SCQ_FETCH: begin
                if (cmd_q_valid) begin
                    s_d.code = cmd_q_data[11:8];
                    s_d.shift = cmd_q_data[7:0];
                    s_d.cnt = '0;
                    s_d.bits = '0;
                    case (cmd_q_data[11:8])
                        SCQ_CMD_RESET: begin
                            s_d.owned = 1'b0;
                            s_d.scl = 1'b1;
                            s_d.sda = 1'b1;
                            s_d.state = SCQ_IDLE;
                        end
                        SCQ_CMD_START: begin
                            s_d.owned = 1'b1;
                            s_d.state = SCQ_START;
                        end
                        SCQ_CMD_STOP: begin
                            s_d.owned = 1'b1;
                            s_d.state = SCQ_STOP;
                        end
                        default: begin
                            if (is_bit_cmd(cmd_q_data[11:8])) begin
                                s_d.owned = 1'b1;
                                s_d.state = SCQ_BIT;
                                if (cmd_q_data[11:8] == SCQ_CMD_MASTER_ACK) begin
                                    s_d.shift = 8'h00;
                                end else if (cmd_q_data[11:8] == SCQ_CMD_MASTER_NOTACK) begin
                                    s_d.shift = 8'hFF;
                                end else if (is_read_cmd(cmd_q_data[11:8])) begin
                                    s_d.shift = 8'hFF;
                                end
                            end
                            // Unknown codes only consume the entry
                        end
                    endcase
                end
            end
            SCQ_START: begin
                // Data high, clock high, then data falls; clock low at period end
                s_d.cnt = s_q.cnt + 1'b1;
                if (s_q.cnt == '0) begin
                    s_d.sda = 1'b1;
                end
                if (s_q.cnt == DELAY_AT) begin
                    s_d.scl = 1'b1;
                end
                if (s_q.cnt == HALF_AT) begin
                    s_d.sda = 1'b0;
                end
                if (s_q.cnt == PERIOD_LAST) begin
                    s_d.scl = 1'b0;
                    s_d.state = SCQ_FETCH;
                end
            end
            SCQ_STOP: begin
                // Data low, clock rises, then data rises with clock high
                s_d.cnt = s_q.cnt + 1'b1;
                if (s_q.cnt == '0) begin
                    s_d.scl = 1'b0;
                end
                if (s_q.cnt == DELAY_AT) begin
                    s_d.sda = 1'b0;
                end
                if (s_q.cnt == HALF_AT) begin
                    s_d.scl = 1'b1;
                end
                if (s_q.cnt == PERIOD_LAST) begin
                    s_d.sda = 1'b1;
                    s_d.state = SCQ_FETCH;
                end
            end
            SCQ_BIT: begin
                // Clock low first half, high second; data changes after delay
                s_d.cnt = s_q.cnt + 1'b1;
                if (s_q.cnt == '0) begin
                    s_d.scl = 1'b0;
                end
                if (s_q.cnt == SDA_AT) begin
                    s_d.sda = s_q.shift[7];
                end
                if (s_q.cnt == HALF_AT) begin
                    s_d.scl = 1'b1;
                end
                if (s_q.cnt == SAMPLE_AT) begin
                    s_d.rsp_data = {s_q.rsp_data[6:0], sda_sync};
                end
                if (s_q.cnt == PERIOD_LAST) begin
                    s_d.scl = 1'b0;
                    s_d.cnt = '0;
                    s_d.shift = {s_q.shift[6:0], 1'b1};
                    s_d.bits = s_q.bits + 1'b1;
                    if (s_q.code == SCQ_CMD_MASTER_ACK || s_q.code == SCQ_CMD_MASTER_NOTACK
                        || s_q.code == SCQ_CMD_SLAVE_ACK_CYCLE
                        || s_q.bits == SCQ_BITS_PER_BYTE - 4'h1) begin
                        s_d.state = is_read_cmd(s_q.code) ? SCQ_PUSH : SCQ_FETCH;
                    end
                end
            end
            SCQ_PUSH: begin
                s_d.rsp_push = 1'b1;
                if (s_q.code == SCQ_CMD_RDATA) begin
                    s_d.rsp_code = SCQ_RSP_READ;
                end else begin
                    s_d.rsp_code = SCQ_RSP_ACK;
                    s_d.rsp_data = s_q.rsp_data[0] ? SCQ_NOTACK_BYTE : SCQ_ACK_BYTE;
                end
                s_d.state = SCQ_FETCH;
            end
            default: begin
                s_d.state = SCQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '{state: SCQ_IDLE, cnt: '0, bits: 4'h0, code: 4'h0, shift: 8'h00,
                     owned: 1'b0, scl: 1'b1, sda: 1'b1, rsp_code: 4'h0,
                     rsp_data: 8'h00, rsp_push: 1'b0};
        end else if (enable_in) begin
            s_q <= s_d;
        end
    end

    // Open-drain drive: only a low is driven, a high releases the line
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_out = s_q.owned && !s_q.scl;
    assign sda_oe_out = s_q.owned && !s_q.sda;
    assign busy_out = (s_q.state != SCQ_FETCH) && (s_q.state != SCQ_IDLE);

    sequence s_start_fetch;
        cmd_pop && (cmd_q_data[11:8] == SCQ_CMD_START);
    endsequence
    sequence s_stop_fetch;
        cmd_pop && (cmd_q_data[11:8] == SCQ_CMD_STOP);
    endsequence

    a_ready_full: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !cmd_q_ready |-> !cmd_ready_out) else $error("Ready high with full command queue");
    a_ready_rsp_full: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !rsp_q_ready |-> !cmd_ready_out) else $error("Ready high with full response queue");
    a_release_unowned: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !s_q.owned |-> (!scl_oe_out && !sda_oe_out)) else $error("Line driven before use");
    a_start_shape: assert property (@(posedge clock_in)
        disable iff (!rst_n_in || !enable_in)
        s_start_fetch ##(HALF + 2) 1 |-> s_q.scl && !s_q.sda)
        else $error("Start condition malformed");
    a_stop_shape: assert property (@(posedge clock_in)
        disable iff (!rst_n_in || !enable_in)
        s_stop_fetch ##(PERIOD_CYCLES + 1) 1 |-> s_q.scl && s_q.sda)
        else $error("Stop condition malformed");
    a_reset_cmd: assert property (@(posedge clock_in)
        disable iff (!rst_n_in || !enable_in)
        reset_cmd |=> !s_q.owned && s_q.state == SCQ_IDLE)
        else $error("Reset command did not release bus");
    a_ack_code: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        s_q.rsp_push && s_q.rsp_code == SCQ_RSP_ACK |-> s_q.rsp_data[7:1] == 7'h00)
        else $error("Acknowledge response malformed");
    a_unknown_idle: assert property (@(posedge clock_in)
        disable iff (!rst_n_in || !enable_in)
        cmd_pop && cmd_q_data[11:8] > SCQ_CMD_SLAVE_ACK_CYCLE |=> s_q.state == SCQ_FETCH)
        else $error("Unknown code caused action");
    a_data_in_low: assert property (@(posedge clock_in)
        disable iff (!rst_n_in || !enable_in)
        s_q.state == SCQ_BIT && $changed(s_q.sda) |-> !s_q.scl)
        else $error("Data changed while clock high");
    // Clock line read back through the synchroniser follows our own pull-down
    a_scl_readback: assert property (@(posedge clock_in)
        disable iff (!rst_n_in || !enable_in)
        scl_oe_out ##1 scl_oe_out ##1 scl_oe_out |-> !scl_sync)
        else $error("Clock line not low while pulled down");
endmodule
`default_nettype wire

// *** verilog/scq_pkg.sv ***
// Package: constants for the two-wire bus master with command queue.
// Assumes nothing of its surroundings.
package scq_pkg;
    localparam int SCQ_PERIOD_CYCLES = 25;
    localparam int SCQ_SDA_DELAY_CYCLES = 5;
    localparam int SCQ_CMD_DEPTH = 16;
    localparam int SCQ_CMD_DEPTH_LOG2 = 4;
    localparam int SCQ_RSP_DEPTH = 16;
    localparam int SCQ_RSP_DEPTH_LOG2 = 4;
    localparam int SCQ_MIN_PERIOD = 4;
    localparam int SCQ_MIN_SDA_DELAY = 2;
    localparam int SCQ_MIN_DEPTH = 2;
    localparam int SCQ_CODE_W = 4;
    localparam int SCQ_BYTE_W = 8;
    localparam int SCQ_ENTRY_W = 12;
    localparam logic [3:0] SCQ_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] SCQ_CMD_RESET = 4'h0;
    localparam logic [3:0] SCQ_CMD_START = 4'h1;
    localparam logic [3:0] SCQ_CMD_STOP = 4'h2;
    localparam logic [3:0] SCQ_CMD_ADDR = 4'h3;
    localparam logic [3:0] SCQ_CMD_WDATA = 4'h4;
    localparam logic [3:0] SCQ_CMD_RDATA = 4'h5;
    localparam logic [3:0] SCQ_CMD_MASTER_ACK = 4'h6;
    localparam logic [3:0] SCQ_CMD_MASTER_NOTACK = 4'h7;
    localparam logic [3:0] SCQ_CMD_SLAVE_ACK_CYCLE = 4'h8;
    localparam logic [3:0] SCQ_RSP_READ = 4'h5;
    localparam logic [3:0] SCQ_RSP_ACK = 4'h8;
    localparam logic [7:0] SCQ_ACK_BYTE = 8'h00;
    localparam logic [7:0] SCQ_NOTACK_BYTE = 8'h01;
    typedef enum logic [2:0] {
        SCQ_IDLE = 3'h0,
        SCQ_FETCH = 3'h1,
        SCQ_START = 3'h2,
        SCQ_STOP = 3'h3,
        SCQ_BIT = 3'h4,
        SCQ_PUSH = 3'h5
    } scq_state_t;
endpackage

// *** verilog/scq_fifo.sv ***
// FIFO of flip-flops with valid/ready on both sides.
// Assumes one clock, active-low asynchronous reset, clock enable.
`timescale 1ns/100ps
`default_nettype none
module scq_fifo
    import scq_pkg::*;
#(
    parameter int WIDTH = SCQ_ENTRY_W,
    parameter int DEPTH = SCQ_CMD_DEPTH,
    parameter int DEPTH_LOG2 = SCQ_CMD_DEPTH_LOG2
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic clear_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    initial begin
        if (DEPTH < SCQ_MIN_DEPTH || (1 << DEPTH_LOG2) != DEPTH) begin
            $error("FIFO depth must be a power of two of at least two");
        end
    end
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [DEPTH_LOG2-1:0] wr;
        logic [DEPTH_LOG2-1:0] rd;
        logic [DEPTH_LOG2:0] count;
    } scq_fifo_state_t;
    scq_fifo_state_t s_q;
    scq_fifo_state_t s_d;
    logic push;
    logic pop;
    assign in_ready_out = (s_q.count != DEPTH[DEPTH_LOG2:0]);
    assign out_valid_out = (s_q.count != '0);
    assign out_data_out = s_q.mem[s_q.rd];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_data_in;
            s_d.wr = s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = s_q.rd + 1'b1;
        end
        s_d.count = s_q.count + {{DEPTH_LOG2{1'b0}}, push} - {{DEPTH_LOG2{1'b0}}, pop};
        if (clear_in) begin
            s_d.wr = '0;
            s_d.rd = '0;
            s_d.count = '0;
        end
    end
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else if (enable_in) begin
            s_q <= s_d;
        end
    end
    a_no_overfill: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        s_q.count <= DEPTH[DEPTH_LOG2:0]) else $error("FIFO count above depth");
endmodule
`default_nettype wire

// *** verilog/scq_sync.sv ***
// Two-flip-flop synchroniser for the bus line levels.
// Assumes asynchronous inputs, active-low reset; lines idle high.
`timescale 1ns/100ps
`default_nettype none
module scq_sync (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic async_in,
    output logic sync_out
);
    typedef struct packed {
        logic first;
        logic second;
    } scq_sync_state_t;
    scq_sync_state_t s_q;
    scq_sync_state_t s_d;
    always_comb begin
        s_d.first = async_in;
        s_d.second = s_q.first;
    end
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= 2'h3;
        end else if (enable_in) begin
            s_q <= s_d;
        end
    end
    assign sync_out = s_q.second;
endmodule
`default_nettype wire

// *** tb/scq_slave_model.sv ***
// Behavioural bus slave: acks its own address, takes writes, returns reads.
// Assumes wired-and line levels with pull-ups are fed back to it.
`timescale 1ns/100ps
`default_nettype none
module scq_slave_model #(
    parameter logic [6:0] ADDR = 7'h5B,
    parameter logic [7:0] RD0 = 8'hC1
) (
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe_out,
    output logic [7:0] rx_byte_out,
    output logic in_frame_out
);
    logic [7:0] sr = 8'h00;
    logic [7:0] rb = 8'h00;
    logic [3:0] bitc = 4'h0;
    logic hit = 1'b0;
    logic rd = 1'b0;
    logic master_ack_cmd = 1'b0;
    logic is_addr = 1'b0;
    logic o;
    initial begin
        sda_oe_out = 1'b0;
        rx_byte_out = 8'h00;
        in_frame_out = 1'b0;
    end
    // Start: data falls while clock high
    always @(negedge sda_in) begin
        if (scl_in) begin
            in_frame_out = 1'b1;
            is_addr = 1'b1;
            rd = 1'b0;
            rb = RD0;
            bitc = 4'hF;
        end
    end
    // Stop: data rises while clock high
    always @(posedge sda_in) begin
        if (scl_in) begin
            in_frame_out = 1'b0;
            sda_oe_out = 1'b0;
        end
    end
    always @(posedge scl_in) begin
        if (bitc < 4'h8)
            sr = {sr[6:0], sda_in};
        else
            master_ack_cmd = !sda_in;
    end
    // Line changes only while the clock is low
    always @(negedge scl_in) begin
        if (in_frame_out) begin
            bitc = bitc + 4'h1;
            o = 1'b0;
            if (bitc == 4'h8) begin
                if (is_addr) begin
                    hit = sr[7:1] == ADDR;
                    rd = sr[0];
                end else if (hit && !rd)
                    rx_byte_out = sr;
                o = hit && (is_addr || !rd);
            end else if (bitc == 4'h9) begin
                bitc = 4'h0;
                if (rd && !is_addr)
                    rb = ~rb;
                if (rd && hit && (is_addr || master_ack_cmd))
                    o = !rb[7];
                is_addr = 1'b0;
            end else if (rd && hit && !is_addr)
                o = !rb[4'h7 - bitc];
            sda_oe_out = o;
        end
    end
endmodule
`default_nettype wire

// *** tb/scq_master_tb.sv ***
// Testbench of the queued bus master against a behavioural slave.
// Assumes pull-ups on both lines and a 20 MHz system clock.
`timescale 1ns/100ps
`default_nettype none
module scq_master_tb;
    import scq_pkg::*;
    localparam int PER = 8;
    localparam int DLY = 2;
    localparam logic [6:0] SLV = 7'h5B;
    localparam logic [7:0] RD0 = 8'hC1;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en = 1'b1;
    logic [3:0] c_code = 4'h0;
    logic [7:0] c_data = 8'h00;
    logic c_valid = 1'b0;
    logic r_ready = 1'b0;
    logic c_ready, scl_oe, sda_oe, r_valid, busy, scl_o, sda_o, s_oe, in_frame;
    logic [3:0] r_code;
    logic [7:0] r_data, rx_byte;
    wire logic scl_w = !scl_oe;
    wire logic sda_w = !(sda_oe || s_oe);
    int fail_count = 0;
    int total_checks = 0;
    always #25 clk = ~clk;
    scq_master #(.PERIOD_CYCLES(PER), .SDA_DELAY_CYCLES(DLY), .CMD_DEPTH(4),
        .CMD_DEPTH_LOG2(2), .RSP_DEPTH(2), .RSP_DEPTH_LOG2(1)) scq_master_inst (
        .clock_in(clk), .rst_n_in(rst_n), .enable_in(en), .cmd_code_in(c_code),
        .cmd_data_in(c_data), .cmd_valid_in(c_valid), .cmd_ready_out(c_ready),
        .scl_in(scl_w), .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_in(sda_w),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .rsp_code_out(r_code),
        .rsp_data_out(r_data), .rsp_valid_out(r_valid), .rsp_ready_in(r_ready),
        .busy_out(busy));
    scq_slave_model #(.ADDR(SLV), .RD0(RD0)) scq_slave_model_inst (.scl_in(scl_w),
        .sda_in(sda_w), .sda_oe_out(s_oe), .rx_byte_out(rx_byte), .in_frame_out(in_frame));
    task automatic test_done();
        if (fail_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_time(input realtime got, input realtime exp);
        total_checks++;
        if (got != exp) begin
            fail_count++;
            $display("CHECK FAILED %0t span %0t expected %0t", $time, got, exp);
        end
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    // Offer one command, hold it until an edge with ready high takes it
    task automatic send(input logic [3:0] c, input logic [7:0] d);
        int n;
        c_code = c;
        c_data = d;
        c_valid = 1'b1;
        n = 0;
        while (c_ready !== 1'b1 && n < 5000) begin
            step();
            n++;
        end
        chk_val({11'h0, c_ready}, 12'h001);
        step();
    endtask
    task automatic pop(input logic [3:0] c, input logic [7:0] d);
        int n;
        n = 0;
        step();
        r_ready = 1'b1;
        while (r_valid !== 1'b1 && n < 5000) begin
            step();
            n++;
        end
        chk_val({11'h0, r_valid}, 12'h001);
        chk_val({r_code, r_data}, {c, d});
        step();
        r_ready = 1'b0;
    endtask
    // Wait until the controller has been idle for four cycles
    task automatic settle();
        int q;
        int n;
        q = 0;
        n = 0;
        c_valid = 1'b0;
        while (q < 4 && n < 5000) begin
            step();
            n++;
            q = (busy === 1'b0) ? q + 1 : 0;
        end
        chk_val(12'(q), 12'h004);
    endtask
    task automatic t_reset();
        chk_val({5'h0, scl_o, sda_o, scl_oe, sda_oe, c_ready, r_valid, busy}, 12'h004);
        repeat (10) step();
        chk_val({10'h0, scl_oe, sda_oe}, 12'h000);
    endtask
    task automatic t_write();
        realtime t0, t1, t2, t3;
        fork
            begin
                @(posedge scl_w) t0 = $realtime;
                @(posedge scl_w) t1 = $realtime;
                @(negedge scl_w) t2 = $realtime;
                @(sda_oe) t3 = $realtime;
            end
            begin
                send(SCQ_CMD_START, 8'h00);
                send(SCQ_CMD_ADDR, {SLV, 1'b0});
                send(SCQ_CMD_SLAVE_ACK_CYCLE, 8'h00);
                send(SCQ_CMD_WDATA, 8'h5A);
                send(SCQ_CMD_SLAVE_ACK_CYCLE, 8'h00);
                settle();
            end
        join
        chk_time(t1 - t0, PER * 50.0);
        chk_time(t3 - t2, DLY * 50.0);
        chk_val({8'h0, in_frame, c_ready, r_valid, 1'b0}, 12'h00A);
        fork
            send(SCQ_CMD_STOP, 8'h00);
            begin
                repeat (10) step();
                chk_val({10'h0, in_frame, c_ready}, 12'h002);
                pop(SCQ_RSP_ACK, SCQ_ACK_BYTE);
                pop(SCQ_RSP_ACK, SCQ_ACK_BYTE);
            end
        join
        settle();
        chk_val({3'h0, in_frame, rx_byte}, 12'h05A);
    endtask
    task automatic t_notack();
        send(SCQ_CMD_START, 8'h00);
        send(SCQ_CMD_ADDR, {7'h22, 1'b0});
        repeat (4) send(4'hF, 8'hFF);
        chk_val({11'h0, c_ready}, 12'h000);
        send(SCQ_CMD_SLAVE_ACK_CYCLE, 8'h00);
        send(SCQ_CMD_STOP, 8'h00);
        settle();
        pop(SCQ_RSP_ACK, SCQ_NOTACK_BYTE);
        chk_val({10'h0, r_valid, in_frame}, 12'h000);
    endtask
    task automatic t_read();
        fork
            begin
                send(SCQ_CMD_START, 8'h00);
                send(SCQ_CMD_ADDR, {SLV, 1'b1});
                send(SCQ_CMD_SLAVE_ACK_CYCLE, 8'h00);
                send(SCQ_CMD_RDATA, 8'h00);
                send(SCQ_CMD_MASTER_ACK, 8'h00);
                send(SCQ_CMD_RDATA, 8'h00);
                send(SCQ_CMD_MASTER_NOTACK, 8'h00);
                send(SCQ_CMD_STOP, 8'h00);
                settle();
            end
            begin
                pop(SCQ_RSP_ACK, SCQ_ACK_BYTE);
                pop(SCQ_RSP_READ, RD0);
                pop(SCQ_RSP_READ, ~RD0);
            end
        join
        chk_val({10'h0, r_valid, in_frame}, 12'h000);
    endtask
    task automatic t_reset_cmd();
        send(SCQ_CMD_START, 8'h00);
        send(SCQ_CMD_ADDR, {SLV, 1'b0});
        send(SCQ_CMD_SLAVE_ACK_CYCLE, 8'h00);
        settle();
        chk_val({10'h0, r_valid, in_frame}, 12'h003);
        send(SCQ_CMD_RESET, 8'hA7);
        settle();
        chk_val({9'h0, scl_oe, sda_oe, r_valid}, 12'h000);
    endtask
    initial begin
        repeat (2) step();
        rst_n = 1'b1;
        t_reset();
        t_write();
        t_notack();
        t_read();
        t_reset_cmd();
        test_done();
    end
    initial begin
        #1000000;
        fail_count++;
        test_done();
    end
endmodule
`default_nettype wire
